// ===== include/fts_pkg.sv
// shared constants and types for the flow-through burst sram core
package fts_pkg;
	// ************************************************************
	// array organisation
	// ************************************************************
	localparam int WIDE_ADDR_W   = 19;  // 512K words
	localparam int WIDE_DATA_W   = 36;
	localparam int NARROW_ADDR_W = 20;  // 1M words
	localparam int NARROW_DATA_W = 18;
	localparam int LANE_W        = 9;   // eight data bits plus parity
	localparam int BURST_W       = 2;   // burst counter covers two address bits
	localparam int BUF_DEPTH     = 2;

	// ************************************************************
	// test access port
	// ************************************************************
	localparam int        IR_W        = 3;
	localparam logic [2:0] IR_IDCODE  = 3'h1;
	localparam logic [2:0] IR_BYPASS  = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;  // pattern loaded in capture-ir
	localparam int        IDCODE_W    = 32;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
		TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
	} fts_tap_type;
endpackage

// ===== rtl/fts_buf.sv
// two-entry write buffer with valid and ready on both sides
`timescale 1ns/10ps
module fts_buf #(
	parameter int W     = 64,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rstn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [W-1:0]     in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [W-1:0]          out_data_o,
	output logic [DEPTH-1:0]      ent_valid_o,
	output logic [DEPTH-1:0][W-1:0] ent_data_o
);
	import fts_pkg::*;

	logic [DEPTH-1:0]        vld_r;
	logic [DEPTH-1:0][W-1:0] dat_r;
	logic                    push;
	logic                    pop;

	// elaboration guard: the shift scheme needs at least two slots
	if (DEPTH < 2 || W < 1) begin : g_bad_cfg
		$error("fts_buf: depth below two not served");
	end

	// entry 0 is always the oldest; a pop shifts everything down
	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;

	// ************************************************************
	// storage shift register
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_ent
			logic up_vld;
			logic up_fill;
			assign up_vld  = (g == DEPTH-1) ? 1'b0 : vld_r[(g == DEPTH-1) ? g : g+1];
			// slot g receives the new word when it is the first free slot after the pop
			assign up_fill = pop ? (up_vld == 1'b0 && vld_r[g]) : (!vld_r[g] &&
				(g == 0 || vld_r[(g == 0) ? 0 : g-1]));
			always_ff @(posedge clk_sys_i or negedge rstn_i) begin
				if (!rstn_i) begin
					vld_r[g] <= 1'b0;
				end else begin
					vld_r[g] <= pop ? (up_vld | (push & up_fill)) : (vld_r[g] | (push & up_fill));
				end
			end
			always_ff @(posedge clk_sys_i) begin
				if (push && up_fill) begin
					dat_r[g] <= in_data_i;
				end else if (pop && g != DEPTH-1) begin
					dat_r[g] <= dat_r[(g == DEPTH-1) ? g : g+1];
				end
			end
		end
	endgenerate

	// ready stays honest: a full buffer refuses unless it drains this edge
	assign in_ready_o  = !vld_r[DEPTH-1] | out_ready_i;
	assign out_valid_o = vld_r[0];
	assign out_data_o  = dat_r[0];
	assign ent_valid_o = vld_r;
	assign ent_data_o  = dat_r;
endmodule

// ===== rtl/fts_sram.sv
// flow-through burst sram core with byte-lane writes and a small test port
`timescale 1ns/10ps
module fts_sram #(
	parameter int          ADDR_W = fts_pkg::WIDE_ADDR_W,
	parameter int          DATA_W = fts_pkg::WIDE_DATA_W,
	parameter logic [31:0] IDCODE = 32'h0000_0001  // arbitrary identification value
) (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rstn_i,
	input  wire logic [ADDR_W-1:0]           addr_i,
	input  wire logic                        advance_or_load_i,
	input  wire logic                        write_n_i,
	input  wire logic [DATA_W/fts_pkg::LANE_W-1:0] byte_lane_write_select_n_i,
	input  wire logic                        chip_select_a_n_i,
	input  wire logic                        chip_select_b_i,
	input  wire logic                        chip_select_c_n_i,
	input  wire logic                        clock_qualify_n_i,
	input  wire logic                        output_enable_n_i,
	input  wire logic                        sleep_request_i,
	input  wire logic                        burst_interleaved_i,
	input  wire logic [DATA_W-1:0]           dq_i,
	output logic [DATA_W-1:0]                dq_o,
	output logic                             dq_oe_o,
	output logic                             low_power_o,
	input  wire logic                        test_clk_i,
	input  wire logic                        test_mode_sel_i,
	input  wire logic                        test_data_i,
	output logic                             test_data_o
);
	import fts_pkg::*;

	localparam int LANES = DATA_W / LANE_W;
	localparam int BUF_W = ADDR_W + LANES + DATA_W;

	// elaboration guard: only the two array shapes are served
	if (!((ADDR_W == WIDE_ADDR_W && DATA_W == WIDE_DATA_W) ||
	      (ADDR_W == NARROW_ADDR_W && DATA_W == NARROW_DATA_W))) begin : g_bad_org
		$error("fts_sram: only the two supported organisations are served");
	end

	// ************************************************************
	// storage and pipeline state
	// ************************************************************
	logic [DATA_W-1:0]  mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0]  base_r;
	logic [BURST_W-1:0] cnt_r;
	logic [ADDR_W-1:0]  cur_addr;
	logic               act_r;      // an access owns the current cycle
	logic               wr_r;       // that access is a write
	logic [LANES-1:0]   mask_n_r;
	logic               sel_now;
	logic               en;
	logic               push;
	logic               buf_in_ready;
	logic               buf_out_valid;
	logic [BUF_W-1:0]   buf_out;
	logic [BUF_DEPTH-1:0]            ent_vld;
	logic [BUF_DEPTH-1:0][BUF_W-1:0] ent_dat;
	logic [DATA_W-1:0]  rd_word;

	// burst sequence on the low address bits
	function automatic logic [BURST_W-1:0] burst_bits(input logic [BURST_W-1:0] start,
	                                                   input logic [BURST_W-1:0] step,
	                                                   input logic inter);
		burst_bits = inter ? (start ^ step) : (start + step);
	endfunction

	// replace the selected lanes of a word with new data
	function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
	                                                 input logic [DATA_W-1:0] new_w,
	                                                 input logic [LANES-1:0] sel_n);
		lane_merge = old_w;
		for (int l = 0; l < LANES; l++) begin
			if (!sel_n[l]) lane_merge[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
		end
	endfunction

	assign cur_addr = {base_r[ADDR_W-1:BURST_W],
	                   burst_bits(base_r[BURST_W-1:0], cnt_r, burst_interleaved_i)};
	assign sel_now  = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i
	                  && !sleep_request_i;
	// write data of the previous write is taken at this edge
	assign push     = act_r && wr_r;
	// a full write buffer stalls like the clock qualify; never loses a word
	assign en       = !clock_qualify_n_i && (!push || buf_in_ready);

	// ************************************************************
	// address and control capture
	// ************************************************************
	// one always_ff: load a new access, advance the burst, or hold on a frozen edge
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			base_r   <= '0;
			cnt_r    <= '0;
			act_r    <= 1'b0;
			wr_r     <= 1'b0;
			mask_n_r <= '1;
		end else if (en) begin
			if (!advance_or_load_i) begin
				base_r   <= addr_i;
				cnt_r    <= '0;
				act_r    <= sel_now;
				wr_r     <= !write_n_i;
				mask_n_r <= byte_lane_write_select_n_i;
			end else begin
				// a continued burst keeps direction; lanes are re-sampled each beat
				cnt_r    <= cnt_r + BURST_W'(1);
				act_r    <= act_r && !sleep_request_i;
				mask_n_r <= byte_lane_write_select_n_i;
			end
		end
	end

	// ************************************************************
	// write path through the buffer into the array
	// ************************************************************
	fts_buf #(
		.W     (BUF_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_sys_i   (clk_sys_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (push && !clock_qualify_n_i),
		.in_ready_o  (buf_in_ready),
		.in_data_i   ({cur_addr, mask_n_r, dq_i}),
		.out_valid_o (buf_out_valid),
		.out_ready_i (!sleep_request_i),
		.out_data_o  (buf_out),
		.ent_valid_o (ent_vld),
		.ent_data_o  (ent_dat)
	);

	// self-timed commit; the array is frozen while asleep so writes wait in the buffer
	always_ff @(posedge clk_sys_i) begin
		if (buf_out_valid && !sleep_request_i) begin
			mem[buf_out[BUF_W-1 -: ADDR_W]] <= lane_merge(mem[buf_out[BUF_W-1 -: ADDR_W]],
				buf_out[DATA_W-1:0], buf_out[DATA_W +: LANES]);
		end
	end

	// ************************************************************
	// flow-through read with forwarding of buffered writes
	// ************************************************************
	// older entries first so the newest write wins on the same address
	always_comb begin
		rd_word = mem[cur_addr];
		for (int e = 0; e < BUF_DEPTH; e++) begin
			if (ent_vld[e] && ent_dat[e][BUF_W-1 -: ADDR_W] == cur_addr)
				rd_word = lane_merge(rd_word, ent_dat[e][DATA_W-1:0],
				                     ent_dat[e][DATA_W +: LANES]);
		end
	end

	// drivers: the read phase is clocked, the enable pin acts at once
	assign dq_o    = rd_word;
	assign dq_oe_o = act_r && !wr_r && !output_enable_n_i;

	// power state follows sleep, the registered select and any write still waiting in the buffer
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_power_o <= 1'b1;
		end else begin
			low_power_o <= sleep_request_i || (!act_r && !buf_out_valid);
		end
	end

	// ************************************************************
	// test access port, test clock sampled on the system clock
	// ************************************************************
	fts_tap_type          tap_r;
	logic                 tck_q_r;
	logic                 tck_rise;
	logic                 tck_fall;
	logic [IR_W-1:0]      ir_r;
	logic [IR_W-1:0]      ir_sh_r;
	logic [IDCODE_W-1:0]  dr_sh_r;

	assign tck_rise = test_clk_i && !tck_q_r;
	assign tck_fall = !test_clk_i && tck_q_r;

	// sixteen-state controller advanced on each test clock rise
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tap_r   <= TAP_RESET;
			tck_q_r <= 1'b0;
		end else begin
			tck_q_r <= test_clk_i;
			if (tck_rise) begin
				unique case (tap_r)
				TAP_RESET:    tap_r <= test_mode_sel_i ? TAP_RESET : TAP_IDLE;
				TAP_IDLE:     tap_r <= test_mode_sel_i ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR:   tap_r <= test_mode_sel_i ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR:   tap_r <= test_mode_sel_i ? TAP_EX1_DR : TAP_SH_DR;
				TAP_SH_DR:    tap_r <= test_mode_sel_i ? TAP_EX1_DR : TAP_SH_DR;
				TAP_EX1_DR:   tap_r <= test_mode_sel_i ? TAP_UPD_DR : TAP_PAUSE_DR;
				TAP_PAUSE_DR: tap_r <= test_mode_sel_i ? TAP_EX2_DR : TAP_PAUSE_DR;
				TAP_EX2_DR:   tap_r <= test_mode_sel_i ? TAP_UPD_DR : TAP_SH_DR;
				TAP_UPD_DR:   tap_r <= test_mode_sel_i ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_IR:   tap_r <= test_mode_sel_i ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR:   tap_r <= test_mode_sel_i ? TAP_EX1_IR : TAP_SH_IR;
				TAP_SH_IR:    tap_r <= test_mode_sel_i ? TAP_EX1_IR : TAP_SH_IR;
				TAP_EX1_IR:   tap_r <= test_mode_sel_i ? TAP_UPD_IR : TAP_PAUSE_IR;
				TAP_PAUSE_IR: tap_r <= test_mode_sel_i ? TAP_EX2_IR : TAP_PAUSE_IR;
				TAP_EX2_IR:   tap_r <= test_mode_sel_i ? TAP_UPD_IR : TAP_SH_IR;
				TAP_UPD_IR:   tap_r <= test_mode_sel_i ? TAP_SEL_DR : TAP_IDLE;
				endcase
			end
		end
	end

	// instruction and data shifting; no boundary chain, other codes select bypass
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ir_r    <= IR_IDCODE;
			ir_sh_r <= '0;
			dr_sh_r <= '0;
		end else if (tck_rise) begin
			unique case (tap_r)
			TAP_RESET:  ir_r    <= IR_IDCODE;
			TAP_CAP_IR: ir_sh_r <= IR_CAPTURE;
			TAP_SH_IR:  ir_sh_r <= {test_data_i, ir_sh_r[IR_W-1:1]};
			TAP_UPD_IR: ir_r    <= ir_sh_r;
			TAP_CAP_DR: dr_sh_r <= (ir_r == IR_IDCODE) ? IDCODE : '0;
			TAP_SH_DR:  dr_sh_r <= (ir_r == IR_IDCODE) ?
			                       {test_data_i, dr_sh_r[IDCODE_W-1:1]} :
			                       {{(IDCODE_W-1){1'b0}}, test_data_i};
			default:    ;
			endcase
		end
	end

	// serial output changes on the falling test clock, as the port expects
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			test_data_o <= 1'b0;
		end else if (tck_fall) begin
			test_data_o <= (tap_r == TAP_SH_IR) ? ir_sh_r[0] :
			               (tap_r == TAP_SH_DR) ? dr_sh_r[0] : 1'b0;
		end
	end
endmodule

// ===== dv/fts_sram_sva.sv
// assertion checker for the memory-side pins of the flow-through burst sram
`timescale 1ns/10ps
module fts_sram_sva #(
	parameter int ADDR_W = 19,
	parameter int DATA_W = 36
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rstn_i,
	input  wire logic              advance_or_load_i,
	input  wire logic              write_n_i,
	input  wire logic              chip_select_a_n_i,
	input  wire logic              chip_select_b_i,
	input  wire logic              chip_select_c_n_i,
	input  wire logic              clock_qualify_n_i,
	input  wire logic              output_enable_n_i,
	input  wire logic              sleep_request_i,
	input  wire logic [DATA_W-1:0] dq_o,
	input  wire logic              dq_oe_o,
	input  wire logic              low_power_o
);
	// **********
	// properties
	// **********
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	logic ld;
	logic cs;
	// a load is a taken edge with a new address; cs is the three-select match
	assign ld = !clock_qualify_n_i && !advance_or_load_i;
	assign cs = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
	property p_oe_off;
		output_enable_n_i |-> !dq_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("drivers on with enable off");
	property p_wr_tri;
		ld && cs && !sleep_request_i && !write_n_i |=> !dq_oe_o;
	endproperty
	a_wr_tri: assert property (p_wr_tri) else $error("drivers on in write data");
	property p_rd_drive;
		ld && cs && !sleep_request_i && write_n_i |=> dq_oe_o == !output_enable_n_i;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
	property p_desel;
		ld && !cs |=> !dq_oe_o;
	endproperty
	a_desel: assert property (p_desel) else $error("deselected cycle drove data");
	property p_slp_desel;
		ld && sleep_request_i |=> !dq_oe_o;
	endproperty
	a_slp_desel: assert property (p_slp_desel) else $error("access while asleep");
	property p_slp_lp;
		sleep_request_i && !clock_qualify_n_i |=> low_power_o;
	endproperty
	a_slp_lp: assert property (p_slp_lp) else $error("sleep without low power");
	// an ignored edge must leave the read output exactly as it was
	property p_frz_q;
		clock_qualify_n_i && dq_oe_o |=> $stable(dq_o);
	endproperty
	a_frz_q: assert property (p_frz_q) else $error("data moved on ignored edge");
	property p_frz_oe;
		clock_qualify_n_i |=> $stable(output_enable_n_i) -> $stable(dq_oe_o);
	endproperty
	a_frz_oe: assert property (p_frz_oe) else $error("enable moved on ignored edge");
	property p_b2b;
		ld && cs && !write_n_i ##1 ld && cs && write_n_i && !sleep_request_i |=>
			dq_oe_o || output_enable_n_i;
	endproperty
	a_b2b: assert property (p_b2b) else $error("read after write stalled");
endmodule
bind fts_sram fts_sram_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) fts_sram_sva_inst (
	.clk_sys_i, .rstn_i, .advance_or_load_i, .write_n_i, .chip_select_a_n_i,
	.chip_select_b_i, .chip_select_c_n_i, .clock_qualify_n_i, .output_enable_n_i,
	.sleep_request_i, .dq_o, .dq_oe_o, .low_power_o
);

// ===== dv/fts_ctrl_model.sv
// memory controller model driving the sram address, control and write data pins
`timescale 1ns/10ps
module fts_ctrl_model (
	input  wire logic        clk_sys_i,
	input  wire logic        clock_qualify_n_i,
	input  wire logic        op_adv_i,
	input  wire logic        op_wr_i,
	input  wire logic [1:0]  op_desel_i,
	input  wire logic [3:0]  op_addr_i,
	input  wire logic [3:0]  op_lanes_i,
	input  wire logic [35:0] op_data_i,
	output logic [18:0]      addr_o,
	output logic             advance_or_load_o,
	output logic             write_n_o,
	output logic [3:0]       lanes_n_o,
	output logic             chip_select_a_n_o,
	output logic             chip_select_b_o,
	output logic             chip_select_c_n_o,
	output logic [35:0]      dq_o
);
	logic burst_wr_r;
	logic wr_nxt;
	initial burst_wr_r = 1'h0;
	initial dq_o = 36'h0_0000_0000;
	// address phase follows the command at once, one command every cycle
	assign addr_o            = {15'h0000, op_addr_i};
	assign advance_or_load_o = op_adv_i;
	assign write_n_o         = !op_wr_i;
	assign lanes_n_o         = op_lanes_i;
	// each deselect code breaks a different one of the three selects
	assign chip_select_a_n_o = (op_desel_i == 2'h1);
	assign chip_select_b_o   = (op_desel_i != 2'h2);
	assign chip_select_c_n_o = (op_desel_i == 2'h3);
	assign wr_nxt = op_adv_i ? burst_wr_r : (op_wr_i && op_desel_i == 2'h0);
	// data phase one taken edge later; a released bus toggles so stale data never passes
	always @(posedge clk_sys_i) begin
		if (!clock_qualify_n_i) begin
			if (!op_adv_i) begin
				burst_wr_r <= wr_nxt;
			end
			dq_o <= wr_nxt ? op_data_i : ~dq_o;
		end
	end
endmodule

// ===== dv/tb_flow_through_burst_sram.sv
// self-checking bench for the flow-through burst sram core
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb_flow_through_burst_sram;
	import fts_pkg::*;
	typedef struct packed {
		logic        adv, wr, ilv;
		logic [1:0]  ds;
		logic [3:0]  a, ln;
		logic [35:0] d;
		logic        eoe;
		logic [35:0] eq;
	} fts_row_type;
	logic              clk_sys_i = 1'h0;
	logic              rstn_i, qn, oen, slp;
	int                miscompares = 0;
	int                check_count = 0;
	logic              ilv = 1'h0, tck = 1'h0, tms = 1'h1, tdi = 1'h0;
	logic [31:0]       id;
	wire logic         tdo;
	localparam logic [31:0] TB_ID = 32'h5A3C_96E1;  // arbitrary identification value
	fts_row_type       op, r;
	wire logic [18:0]  addr;
	wire logic         adv, wn, can, cb, ccn, dq_oe_o, low_power_o;
	wire logic [3:0]   ln;
	wire logic [35:0]  ctl_dq, dq_o, dq_w;
	// writes, partial-lane writes, linear and interleaved bursts, deselects
	fts_row_type rows [20] = '{
		'{1'h0,1'h1,1'h0,2'h0,4'h4,4'h0,36'h0_0000_0000,1'h0,36'h0},
		'{1'h0,1'h0,1'h0,2'h0,4'h4,4'hF,36'h0,1'h1,36'h0_0000_0000},
		'{1'h0,1'h1,1'h0,2'h0,4'h4,4'hA,36'hF_FFFF_FFFF,1'h0,36'h0},
		'{1'h0,1'h0,1'h0,2'h0,4'h4,4'hF,36'h0,1'h1,36'h0_07FC_01FF},
		'{1'h0,1'h1,1'h0,2'h0,4'h8,4'h0,36'hA_0000_0008,1'h0,36'h0},
		'{1'h1,1'h1,1'h0,2'h0,4'h0,4'h0,36'hA_0000_0009,1'h0,36'h0},
		'{1'h1,1'h1,1'h0,2'h0,4'h0,4'h0,36'hA_0000_000A,1'h0,36'h0},
		'{1'h1,1'h1,1'h0,2'h0,4'h0,4'h0,36'hA_0000_000B,1'h0,36'h0},
		'{1'h0,1'h0,1'h0,2'h0,4'h9,4'hF,36'h0,1'h1,36'hA_0000_0009},
		'{1'h1,1'h0,1'h0,2'h0,4'h0,4'hF,36'h0,1'h1,36'hA_0000_000A},
		'{1'h1,1'h0,1'h0,2'h0,4'h0,4'hF,36'h0,1'h1,36'hA_0000_000B},
		'{1'h1,1'h0,1'h0,2'h0,4'h0,4'hF,36'h0,1'h1,36'hA_0000_0008},
		'{1'h0,1'h0,1'h1,2'h0,4'h9,4'hF,36'h0,1'h1,36'hA_0000_0009},
		'{1'h1,1'h0,1'h1,2'h0,4'h0,4'hF,36'h0,1'h1,36'hA_0000_0008},
		'{1'h1,1'h0,1'h1,2'h0,4'h0,4'hF,36'h0,1'h1,36'hA_0000_000B},
		'{1'h1,1'h0,1'h1,2'h0,4'h0,4'hF,36'h0,1'h1,36'hA_0000_000A},
		'{1'h0,1'h0,1'h0,2'h1,4'h4,4'hF,36'h0,1'h0,36'h0},
		'{1'h0,1'h0,1'h0,2'h2,4'h4,4'hF,36'h0,1'h0,36'h0},
		'{1'h0,1'h0,1'h0,2'h3,4'h4,4'hF,36'h0,1'h0,36'h0},
		'{1'h0,1'h0,1'h0,2'h0,4'h4,4'hF,36'h0,1'h1,36'h0_07FC_01FF}};
	// the shared data wire: the sram drives it while enabled, else the controller
	assign dq_w = dq_oe_o ? dq_o : ctl_dq;
	fts_sram #(.IDCODE(TB_ID)) fts_sram_inst (.clk_sys_i, .rstn_i, .addr_i(addr),
		.advance_or_load_i(adv),
		.write_n_i(wn), .byte_lane_write_select_n_i(ln), .chip_select_a_n_i(can),
		.chip_select_b_i(cb), .chip_select_c_n_i(ccn), .clock_qualify_n_i(qn),
		.output_enable_n_i(oen), .sleep_request_i(slp), .burst_interleaved_i(ilv),
		.dq_i(dq_w), .dq_o, .dq_oe_o, .low_power_o, .test_clk_i(tck),
		.test_mode_sel_i(tms), .test_data_i(tdi), .test_data_o(tdo));
	// burst order pin follows the row taken at this edge, so a check never sees the next row's order
	always @(posedge clk_sys_i) ilv <= op.ilv;
	fts_ctrl_model fts_ctrl_model_inst (.clk_sys_i, .clock_qualify_n_i(qn),
		.op_adv_i(op.adv), .op_wr_i(op.wr), .op_desel_i(op.ds), .op_addr_i(op.a),
		.op_lanes_i(op.ln), .op_data_i(op.d), .addr_o(addr), .advance_or_load_o(adv),
		.write_n_o(wn), .lanes_n_o(ln), .chip_select_a_n_o(can), .chip_select_b_o(cb),
		.chip_select_c_n_o(ccn), .dq_o(ctl_dq));
	always #20 clk_sys_i = ~clk_sys_i;
	task automatic results;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one slow test clock period of six system cycles, high for two and low for four, for the edge sampler
	task automatic tck_cyc(input logic m);
		@(posedge clk_sys_i) tms <= m;
		@(posedge clk_sys_i) tck <= 1'h1;
		repeat (2) @(posedge clk_sys_i);
		tck <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
	endtask
	// hang guard: the sequence needs about two hundred fifty cycles
	initial begin
		#(40 * 1000);
		miscompares++;
		results();
	end
	// reset, the row table, then freeze and sleep by hand
	initial begin
		rstn_i = 1'h0;
		qn = 1'h0;
		oen = 1'h0;
		slp = 1'h0;
		op = rows[16];
		@(negedge clk_sys_i);
		`CHK("rst_oe", 1'h0, dq_oe_o)
		`CHK("rst_lp", 1'h1, low_power_o)
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'h1;
		for (int i = 0; i <= 20; i++) begin
			@(posedge clk_sys_i) op <= (i < 20) ? rows[i] : rows[16];
			@(negedge clk_sys_i);
			if (i > 0) begin
				r = rows[i-1];
				`CHK("oe", r.eoe, dq_oe_o)
				if (r.eoe) `CHK("q", r.eq, dq_o)
			end
		end
		@(posedge clk_sys_i) op <= rows[3];
		@(posedge clk_sys_i) begin
			qn <= 1'h1;
			oen <= 1'h1;
			op <= rows[0];
		end
		@(negedge clk_sys_i) `CHK("oe_async", 1'h0, dq_oe_o)
		@(posedge clk_sys_i) oen <= 1'h0;
		@(negedge clk_sys_i) `CHK("frz_q", 36'h0_07FC_01FF, dq_o)
		@(posedge clk_sys_i) begin
			qn <= 1'h0;
			op <= rows[3];
		end
		@(posedge clk_sys_i);
		@(negedge clk_sys_i) `CHK("frz_wr", 36'h0_07FC_01FF, dq_o)
		@(posedge clk_sys_i) begin
			slp <= 1'h1;
			op <= rows[1];
		end
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i) `CHK("slp_oe", 1'h0, dq_oe_o)
		`CHK("slp_lp", 1'h1, low_power_o)
		@(posedge clk_sys_i) begin
			slp <= 1'h0;
			op <= rows[16];
		end
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i) `CHK("idle_lp", 1'h1, low_power_o)
		@(posedge clk_sys_i) op <= rows[1];
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i) `CHK("busy_lp", 1'h0, low_power_o)
		// walk to the data shift state and read the identification word, low bit first
		tck_cyc(1'h0);
		tck_cyc(1'h1);
		tck_cyc(1'h0);
		for (int k = 0; k < 32; k++) begin
			tck_cyc(1'h0);
			@(negedge clk_sys_i) id[k] = tdo;
		end
		`CHK("idcode", TB_ID, id)
		results();
	end
endmodule
